// ---- rtl/crb_map.vh ----
/*
 * Constants of the reset and boot sequencer: register offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design files under rtl/.
 */
`ifndef CRB_MAP_VH
`define CRB_MAP_VH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the APB.
`define CRB_OFF_CTRL      8'h00
`define CRB_OFF_FLUSH     8'h04
`define CRB_OFF_STATUS    8'h08

////////////////////////////////////////////////////////////////////////////
// Control and status fields of ibox_control_status_reg.
`define CRB_CTRL_DONE     0
`define CRB_CTRL_FAIL     1
`define CRB_CTRL_LOADED   2
`define CRB_CTRL_STEN     8
`define CRB_CTRL_STEN_RST 1'b1

////////////////////////////////////////////////////////////////////////////
// Fields of the status register.
`define CRB_ST_STATE_LSB  0
`define CRB_ST_RATIO_LSB  4
`define CRB_ST_DELAY_LSB  8
`define CRB_ST_PG         12
`define CRB_ST_ROMP       13

////////////////////////////////////////////////////////////////////////////
// Reset values and commands.
`define CRB_CMD_NOP       4'h0
`define CRB_RATIO_RST     4'h0
`define CRB_DELAY_RST     3'h0
`define CRB_FETCH_ENTRY   40'h00_0000_0000

////////////////////////////////////////////////////////////////////////////
// Timing counts in processor clock cycles, and fill bit and line counts.
`define CRB_ROM_PERIOD    126
`define CRB_ROM_HALF      7'd63
`define CRB_FILL_BITS     8'd200
`define CRB_IC_BLOCKS     9'd256
`define CRB_CACHE_SELF_TEST_CYCLES   12'd1024

`endif

// ---- rtl/crb_rom_loader.v ----
/*
 * Serial ROM cache loader: makes the ROM clock, samples the serial data
 * and reports each bit, each completed fill line and the end of the load.
 * Assumes the ROM presents the next bit after each rising ROM clock edge.
 */
`include "crb_map.vh"

module crb_rom_loader (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       start,
  input  wire       abort,
  input  wire       rom_data,
  output reg        rom_clk_reg,
  output reg        busy_reg,
  output reg        bit_valid_reg,
  output reg        bit_value_reg,
  output reg        line_done_reg,
  output reg  [7:0] line_index_reg,
  output reg        done_reg
);

  reg [1:0] data_sync_reg;
  reg [6:0] half_cnt_reg;
  reg [7:0] bit_cnt_reg;
  reg [8:0] line_cnt_reg;

  ////////////////////////////////////////////////////////////////////////
  // The second synchroniser stage is the only reader of the first.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_sync_reg  <= 2'b00;
      rom_clk_reg    <= 1'b0;
      busy_reg       <= 1'b0;
      bit_valid_reg  <= 1'b0;
      bit_value_reg  <= 1'b0;
      line_done_reg  <= 1'b0;
      line_index_reg <= 8'h00;
      done_reg       <= 1'b0;
      half_cnt_reg   <= 7'h00;
      bit_cnt_reg    <= 8'h00;
      line_cnt_reg   <= 9'h000;
    end else begin
      data_sync_reg <= {data_sync_reg[0], rom_data};
      bit_valid_reg <= 1'b0;
      line_done_reg <= 1'b0;
      done_reg      <= 1'b0;
      // Reset or lost power stops a load at once and parks the ROM clock.
      if (abort) begin
        busy_reg    <= 1'b0;
        rom_clk_reg <= 1'b0;
      end else if (start && !busy_reg) begin
        busy_reg     <= 1'b1;
        half_cnt_reg <= 7'h00;
        bit_cnt_reg  <= 8'h00;
        line_cnt_reg <= 9'h000;
        rom_clk_reg  <= 1'b0;
      end else if (busy_reg) begin
        if (half_cnt_reg == `CRB_ROM_HALF - 7'd1) begin
          half_cnt_reg <= 7'h00;
          rom_clk_reg  <= ~rom_clk_reg;
          if (!rom_clk_reg) begin
            bit_valid_reg <= 1'b1;
            bit_value_reg <= data_sync_reg[1];
            if (bit_cnt_reg == `CRB_FILL_BITS - 8'd1) begin
              bit_cnt_reg    <= 8'h00;
              line_done_reg  <= 1'b1;
              line_index_reg <= line_cnt_reg[7:0];
              line_cnt_reg   <= line_cnt_reg + 9'd1;
              if (line_cnt_reg == `CRB_IC_BLOCKS - 9'd1) begin
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
              end
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 8'd1;
            end
          end
        end else begin
          half_cnt_reg <= half_cnt_reg + 7'd1;
        end
      end else begin
        rom_clk_reg <= 1'b0;
      end
    end
  end

endmodule

// ---- rtl/crb_sequencer.v ----
/*
 * Processor power-up and reset sequencer with an APB register slave.
 * Qualifies power good and system reset, selects the clock source,
 * latches clock straps, sets pin reset states, then runs the cache
 * self-test, the optional serial ROM load and the reset-entry dispatch.
 * Assumes pclk is the processor clock; pins are asynchronous to it.
 */
`include "crb_map.vh"

module crb_sequencer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        power_good,
  input  wire        sys_reset_n,
  input  wire [3:0]  ratio_pins,
  input  wire [2:0]  delay_pins,
  input  wire        addr_bus_req,
  input  wire        rom_present_n,
  input  wire        rom_data,
  input  wire        st_error,
  output reg         osc_select,
  output reg  [3:0]  sysclk_ratio,
  output reg  [2:0]  secondary_system_clock_out,
  output reg         core_reset_n,
  output reg         pin_pulldown_en,
  output reg         cache_bus_oe,
  output reg         cache_ram_en,
  output reg         store_clk_en,
  output reg         addr_cmd_oe,
  output reg  [3:0]  cmd_out,
  output wire        rom_clk,
  output reg         rom_oe_n,
  output reg  [1:0]  self_test_status,
  output reg         self_test_run,
  output reg         icache_flush,
  output reg         scache_flush,
  output wire        icache_fill_bit,
  output wire        icache_fill_shift,
  output wire        icache_fill_write,
  output wire [7:0]  icache_fill_index,
  output reg         fetch_req,
  output reg  [39:0] fetch_addr
);

  localparam [2:0] S_OFF   = 3'd0;
  localparam [2:0] S_RESET = 3'd1;
  localparam [2:0] S_CACHE_SELF_TEST  = 3'd2;
  localparam [2:0] S_FLUSH = 3'd3;
  localparam [2:0] S_LOAD  = 3'd4;
  localparam [2:0] S_FETCH = 3'd5;
  localparam [2:0] S_RUN   = 3'd6;

  reg  [1:0]  pg_sync_reg;
  reg  [2:0]  rst_sync_reg;
  reg  [1:0]  req_sync_reg;
  reg  [1:0]  romp_sync_reg;
  reg  [3:0]  ratio_s1_reg;
  reg  [3:0]  ratio_s2_reg;
  reg  [2:0]  delay_s1_reg;
  reg  [2:0]  delay_s2_reg;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [11:0] cache_self_test_cnt_reg;
  reg         cache_self_test_fail_reg;
  reg         cache_self_test_done_reg;
  reg         rom_seen_reg;
  reg         loaded_reg;
  reg         st_enable_reg;
  reg         sw_flush_reg;
  reg         load_start_reg;
  wire        pg_ok;
  wire        rst_on;
  wire        in_reset;
  wire        wr_done;
  wire        rd_phase;
  wire        load_busy;
  wire        load_done;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the last stage of each is read by logic.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_sync_reg   <= 2'b00;
      rst_sync_reg  <= 3'b000;
      req_sync_reg  <= 2'b00;
      romp_sync_reg <= 2'b11;
      ratio_s1_reg  <= `CRB_RATIO_RST;
      ratio_s2_reg  <= `CRB_RATIO_RST;
      delay_s1_reg  <= `CRB_DELAY_RST;
      delay_s2_reg  <= `CRB_DELAY_RST;
    end else begin
      pg_sync_reg   <= {pg_sync_reg[0], power_good};
      // A third stage gives the asynchronous release extra margin.
      rst_sync_reg  <= {rst_sync_reg[1:0], sys_reset_n};
      req_sync_reg  <= {req_sync_reg[0], addr_bus_req};
      romp_sync_reg <= {romp_sync_reg[0], rom_present_n};
      ratio_s1_reg  <= ratio_pins;
      ratio_s2_reg  <= ratio_s1_reg;
      delay_s1_reg  <= delay_pins;
      delay_s2_reg  <= delay_s1_reg;
    end
  end

  assign pg_ok    = pg_sync_reg[1];
  // Missing power good overrides whatever the reset pin shows.
  assign rst_on   = !pg_ok || !rst_sync_reg[2];
  assign in_reset = (state_reg == S_OFF) || (state_reg == S_RESET);

  ////////////////////////////////////////////////////////////////////////
  // Boot sequence.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_OFF: begin
        if (pg_ok) begin
          state_next = S_RESET;
        end
      end
      S_RESET: begin
        if (!rst_on) begin
          if (st_enable_reg) begin
            state_next = S_CACHE_SELF_TEST;
          end else begin
            state_next = S_FLUSH;
          end
        end
      end
      S_CACHE_SELF_TEST: begin
        if (cache_self_test_cnt_reg == `CRB_CACHE_SELF_TEST_CYCLES - 12'd1) begin
          state_next = S_FLUSH;
        end
      end
      S_FLUSH: begin
        if (rom_seen_reg) begin
          state_next = S_LOAD;
        end else begin
          state_next = S_FETCH;
        end
      end
      S_LOAD: begin
        if (load_done) begin
          state_next = S_FETCH;
        end
      end
      S_FETCH: begin
        state_next = S_RUN;
      end
      S_RUN: begin
        state_next = S_RUN;
      end
      default: begin
        state_next = S_OFF;
      end
    endcase
    if (!pg_ok) begin
      state_next = S_OFF;
    end else if (rst_on && state_reg != S_OFF) begin
      state_next = S_RESET;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= S_OFF;
      cache_self_test_cnt_reg   <= 12'h000;
      cache_self_test_fail_reg  <= 1'b0;
      cache_self_test_done_reg  <= 1'b0;
      rom_seen_reg   <= 1'b0;
      loaded_reg     <= 1'b0;
      load_start_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      load_start_reg <= (state_reg == S_FLUSH) && rom_seen_reg;
      if (in_reset) begin
        // Presence is sampled throughout reset; the last value counts.
        rom_seen_reg  <= !romp_sync_reg[1];
        cache_self_test_cnt_reg  <= 12'h000;
        cache_self_test_fail_reg <= 1'b0;
        cache_self_test_done_reg <= 1'b0;
        loaded_reg    <= 1'b0;
      end else if (state_reg == S_CACHE_SELF_TEST) begin
        cache_self_test_cnt_reg  <= cache_self_test_cnt_reg + 12'd1;
        cache_self_test_fail_reg <= cache_self_test_fail_reg | st_error;
        if (state_next != S_CACHE_SELF_TEST) begin
          cache_self_test_done_reg <= 1'b1;
        end
      end
      if (load_done) begin
        loaded_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin states, clock source and straps.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_select       <= 1'b0;
      sysclk_ratio     <= `CRB_RATIO_RST;
      secondary_system_clock_out <= `CRB_DELAY_RST;
      core_reset_n     <= 1'b0;
      pin_pulldown_en  <= 1'b1;
      cache_bus_oe     <= 1'b0;
      cache_ram_en     <= 1'b0;
      store_clk_en     <= 1'b0;
      addr_cmd_oe      <= 1'b0;
      cmd_out          <= `CRB_CMD_NOP;
      rom_oe_n         <= 1'b1;
      self_test_status <= 2'b00;
      self_test_run    <= 1'b0;
      fetch_req        <= 1'b0;
      fetch_addr       <= `CRB_FETCH_ENTRY;
    end else begin
      osc_select      <= pg_ok;
      pin_pulldown_en <= !pg_ok;
      // Straps follow the pins three cycles late while reset lasts.
      if (rst_on) begin
        sysclk_ratio               <= ratio_s2_reg;
        secondary_system_clock_out <= delay_s2_reg;
      end
      // Core stays in reset through the self-test.
      core_reset_n <= (state_next == S_FLUSH) || (state_next == S_LOAD)
                   || (state_next == S_FETCH)
                   || (state_next == S_RUN);
      cache_bus_oe <= (state_next == S_RUN);
      cache_ram_en <= (state_next == S_RUN);
      store_clk_en <= (state_next == S_RUN);
      if (state_next == S_RUN) begin
        addr_cmd_oe <= 1'b1;
      end else if (pg_ok) begin
        addr_cmd_oe <= req_sync_reg[1];
      end else begin
        addr_cmd_oe <= 1'b0;
      end
      cmd_out       <= `CRB_CMD_NOP;
      rom_oe_n      <= !(state_next == S_LOAD);
      self_test_run <= (state_next == S_CACHE_SELF_TEST);
      if (rst_on) begin
        self_test_status <= 2'b00;
      end else if (cache_self_test_done_reg) begin
        self_test_status <= {1'b0, !cache_self_test_fail_reg};
      end
      fetch_req  <= (state_reg == S_FETCH);
      fetch_addr <= `CRB_FETCH_ENTRY;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cache flush strobes: reset flush before any load, and software flush.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icache_flush <= 1'b0;
      scache_flush <= 1'b0;
    end else begin
      icache_flush <= (state_next == S_FLUSH)
                   || sw_flush_reg;
      scache_flush <= (state_next == S_FLUSH);
    end
  end

  crb_rom_loader i_crb_rom_loader (
    .pclk           (pclk),
    .presetn        (presetn),
    .start          (load_start_reg),
    .abort          (rst_on),
    .rom_data       (rom_data),
    .rom_clk_reg    (rom_clk),
    .busy_reg       (load_busy),
    .bit_valid_reg  (icache_fill_shift),
    .bit_value_reg  (icache_fill_bit),
    .line_done_reg  (icache_fill_write),
    .line_index_reg (icache_fill_index),
    .done_reg       (load_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB slave with one wait state; writes land at the completing edge.
  assign rd_phase = psel && penable && !pready;
  assign wr_done  = psel && penable && pready && pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      prdata        <= 32'h0000_0000;
      st_enable_reg <= `CRB_CTRL_STEN_RST;
      sw_flush_reg  <= 1'b0;
    end else begin
      pready       <= rd_phase;
      sw_flush_reg <= 1'b0;
      if (rd_phase) begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
        case (paddr)
          `CRB_OFF_CTRL: begin
            if (!pwrite) begin
              prdata[`CRB_CTRL_DONE]   <= cache_self_test_done_reg;
              prdata[`CRB_CTRL_FAIL]   <= cache_self_test_fail_reg;
              prdata[`CRB_CTRL_LOADED] <= loaded_reg;
              prdata[`CRB_CTRL_STEN]   <= st_enable_reg;
            end
          end
          `CRB_OFF_FLUSH: begin
            prdata <= 32'h0000_0000;
          end
          `CRB_OFF_STATUS: begin
            if (!pwrite) begin
              prdata[`CRB_ST_STATE_LSB+2:`CRB_ST_STATE_LSB] <= state_reg;
              prdata[`CRB_ST_RATIO_LSB+3:`CRB_ST_RATIO_LSB] <= sysclk_ratio;
              prdata[`CRB_ST_DELAY_LSB+2:`CRB_ST_DELAY_LSB]
                <= secondary_system_clock_out;
              prdata[`CRB_ST_PG]   <= pg_ok;
              prdata[`CRB_ST_ROMP] <= rom_seen_reg;
            end
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end else begin
        pslverr <= 1'b0;
      end
      if (wr_done && paddr == `CRB_OFF_CTRL) begin
        st_enable_reg <= pwdata[`CRB_CTRL_STEN];
      end
      if (wr_done && paddr == `CRB_OFF_FLUSH) begin
        sw_flush_reg <= 1'b1;
      end
    end
  end

endmodule

// ---- bench/crb_seq_sva.sv ----
/* Pin checker of the reset and boot sequencer.
   Assumes it is bound to crb_sequencer and sees only pclk. */
`include "crb_map.vh"
module crb_seq_sva (
  input logic        pclk,
  input logic        presetn,
  input logic [7:0]  paddr,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic        pready,
  input logic        power_good,
  input logic        sys_reset_n,
  input logic [3:0]  ratio_pins,
  input logic [2:0]  delay_pins,
  input logic        st_error,
  input logic        osc_select,
  input logic [3:0]  sysclk_ratio,
  input logic [2:0]  secondary_system_clock_out,
  input logic        core_reset_n,
  input logic        pin_pulldown_en,
  input logic        cache_bus_oe,
  input logic        cache_ram_en,
  input logic        store_clk_en,
  input logic        addr_cmd_oe,
  input logic [3:0]  cmd_out,
  input logic        rom_clk,
  input logic        rom_oe_n,
  input logic [1:0]  self_test_status,
  input logic        self_test_run,
  input logic        icache_flush,
  input logic        scache_flush,
  input logic        fetch_req,
  input logic [39:0] fetch_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic err_seen;
  ////////////////////////////////////////////////////////////////////////
  // Remembers a miscompare seen during the current self-test run.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      err_seen <= 1'b0;
    else if ($rose(self_test_run))
      err_seen <= st_error;
    else if (self_test_run && st_error)
      err_seen <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  a_off_reset: assert property (
    !power_good [*5] |-> !core_reset_n) else $error("core runs unpowered");
  a_ring_osc: assert property (
    !power_good [*5] |-> !osc_select && pin_pulldown_en)
    else $error("ring source or pull-down wrong");
  a_ext_osc: assert property (
    power_good [*5] |-> osc_select && !pin_pulldown_en)
    else $error("external source not selected");
  a_cache_self_test_hold: assert property (
    self_test_run |-> !core_reset_n) else $error("core free in self-test");
  a_cmd_nop: assert property (
    addr_cmd_oe |-> cmd_out == `CRB_CMD_NOP) else $error("command not nop");
  a_reset_quiet: assert property (
    !sys_reset_n [*5] |-> !cache_bus_oe && !cache_ram_en && !store_clk_en
    && rom_oe_n && !rom_clk && self_test_status == 2'b00)
    else $error("pins active in reset");
  a_straps_take: assert property (
    (!sys_reset_n && power_good && $stable(ratio_pins)
    && $stable(delay_pins)) [*5] |-> sysclk_ratio == ratio_pins
    && secondary_system_clock_out == delay_pins)
    else $error("straps not taken");
  a_sync_wait: assert property (
    $rose(sys_reset_n) |-> !self_test_run [*2])
    else $error("self-test before sync");
  a_boot_flush: assert property (
    $fell(self_test_run) && sys_reset_n && power_good
    |-> ##[0:3] icache_flush && scache_flush)
    else $error("no flush after self-test");
  a_test_result: assert property (
    $fell(self_test_run) && sys_reset_n && power_good
    |-> ##[0:3] self_test_status[0] == !err_seen)
    else $error("self-test result wrong");
  a_flush_write: assert property (
    psel && penable && pready && pwrite && paddr == `CRB_OFF_FLUSH
    |-> ##2 icache_flush) else $error("flush write ignored");
  a_fetch_zero: assert property (
    fetch_req |-> fetch_addr == `CRB_FETCH_ENTRY ##1 !fetch_req)
    else $error("bad reset fetch");
  c_fetch: cover property (fetch_req);
  c_load: cover property ($fell(rom_oe_n));
  c_flush: cover property (icache_flush && !scache_flush);
endmodule
bind crb_sequencer crb_seq_sva i_crb_seq_sva (.*);

// ---- bench/crb_board_model.sv ----
/* Board power and reset controller model.
   Assumes the bench sets power_on, reset_req and the strap values. */
module crb_board_model #(
  parameter int HOLD = 400
) (
  input  logic       pclk,
  input  logic       power_on,
  input  logic       reset_req,
  input  logic [3:0] ratio_cfg,
  input  logic [2:0] delay_cfg,
  input  logic       rom_oe_n,
  input  logic       rom_clk,
  output logic       power_good,
  output logic       sys_reset_n,
  output logic [3:0] ratio_pins,
  output logic [2:0] delay_pins,
  output logic       rom_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int   pg_cnt;
  int   rst_cnt;
  logic rst_q;
  logic clk_q;
  initial begin
    power_good = 1'b0;
    rst_q = 1'b0;
    clk_q = 1'b0;
    rom_data = 1'b0;
    pg_cnt = 0;
    rst_cnt = 0;
  end
  // Straps stay driven the whole time.
  assign ratio_pins = ratio_cfg;
  assign delay_pins = delay_cfg;
  // Release lands off the clock edge.
  assign #3 sys_reset_n = rst_q;
  always @(posedge pclk) begin
    clk_q <= rom_clk;
    // Unselected ROM data keeps changing; selected it steps per ROM clock.
    if (rom_oe_n || (rom_clk && !clk_q)) begin
      rom_data <= ~rom_data;
    end
    if (!power_on) begin
      pg_cnt <= 0;
      power_good <= 1'b0;
      rst_cnt <= 0;
      rst_q <= 1'b0;
    end else begin
      if (pg_cnt < 10)
        pg_cnt <= pg_cnt + 1;
      else
        power_good <= 1'b1;
      if (!power_good || reset_req) begin
        rst_cnt <= 0;
        rst_q <= 1'b0;
      end else if (rst_cnt < HOLD)
        rst_cnt <= rst_cnt + 1;
      else
        rst_q <= 1'b1;
    end
  end
endmodule

// ---- bench/crb_sequencer_tb_top.sv ----
/* Self-checking bench of the reset and boot sequencer.
   Assumes the board model and the checker compile beside it. */
`include "crb_map.vh"
module crb_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        power_good, sys_reset_n, addr_bus_req, rom_present_n;
  logic        rom_data, st_error, osc_select, core_reset_n;
  logic        pin_pulldown_en, cache_bus_oe, cache_ram_en, store_clk_en;
  logic        addr_cmd_oe, rom_clk, rom_oe_n, self_test_run;
  logic        icache_flush, scache_flush, fetch_req, power_on, reset_req;
  logic        icache_fill_bit, icache_fill_shift, icache_fill_write;
  logic [7:0]  paddr, icache_fill_index;
  logic [31:0] pwdata, prdata;
  logic [3:0]  ratio_pins, sysclk_ratio, cmd_out, ratio_cfg;
  logic [2:0]  delay_pins, secondary_system_clock_out, delay_cfg;
  logic [1:0]  self_test_status;
  logic [39:0] fetch_addr;
  int          error_cnt, num_checks, flush_cnt, cyc, t0;
  int          shift_cnt, ones_cnt;
  crb_sequencer i_crb_sequencer (.*);
  crb_board_model i_crb_board_model (.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (icache_flush === 1'b1)
      flush_cnt <= flush_cnt + 1;
    if (icache_fill_shift === 1'b1) begin
      shift_cnt <= shift_cnt + 1;
      ones_cnt  <= ones_cnt + icache_fill_bit;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      chk("pready", 1, pready);
      end_of_test();
    end
    if (!w)
      chk("prdata", d, prdata);
    chk("pslverr", err, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_for(input int sel, input int lim);
    int   k;
    logic hit;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
      case (sel)
        0: hit = self_test_run === 1'b1;
        1: hit = fetch_req === 1'b1;
        2: hit = rom_oe_n === 1'b0;
        3: hit = rom_clk === 1'b1;
        5: hit = icache_fill_write === 1'b1;
        default: hit = rom_clk === 1'b0;
      endcase
    end while (!hit && k < lim);
    if (!hit) begin
      chk("wait", sel, -1);
      end_of_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {power_on, reset_req, addr_bus_req, st_error} = '0;
    rom_present_n = 1'b1;
    ratio_cfg = 4'h5;
    delay_cfg = 3'h6;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("pulldown", 1, pin_pulldown_en);
    chk("osc", 0, osc_select);
    chk("core_rst", 0, core_reset_n);
    power_on <= 1'b1;
    repeat (30) @(posedge pclk);
    chk("osc", 1, osc_select);
    chk("ratio", 4'h5, sysclk_ratio);
    chk("delay", 3'h6, secondary_system_clock_out);
    addr_bus_req <= 1'b1;
    ratio_cfg <= 4'ha;
    delay_cfg <= 3'h1;
    repeat (20) @(posedge pclk);
    chk("ratio", 4'ha, sysclk_ratio);
    chk("delay", 3'h1, secondary_system_clock_out);
    chk("cmd_oe", 1, addr_cmd_oe);
    chk("cmd", `CRB_CMD_NOP, cmd_out);
    addr_bus_req <= 1'b0;
    apb(0, `CRB_OFF_STATUS, 32'h11a1, 0);
    chk("cmd_oe", 0, addr_cmd_oe);
    wait_for(0, 500);
    chk("core_rst", 0, core_reset_n);
    wait_for(1, 1200);
    chk("fetch_addr", 0, fetch_addr);
    chk("flushes", 1, flush_cnt);
    chk("rom_oe_n", 1, rom_oe_n);
    chk("st_status", 2'b01, self_test_status);
    repeat (3) @(posedge pclk);
    chk("bus_oe", 1, cache_bus_oe);
    apb(0, `CRB_OFF_CTRL, 32'h101, 0);
    apb(1, `CRB_OFF_FLUSH, 32'h1, 0);
    repeat (3) @(posedge pclk);
    chk("flushes", 2, flush_cnt);
    apb(0, `CRB_OFF_FLUSH, 32'h0, 0);
    apb(0, 8'h0c, 32'h0, 1);
    apb(1, 8'h10, 32'h5, 1);
    // Second boot: failing self-test, then a serial load.
    st_error <= 1'b1;
    rom_present_n <= 1'b0;
    reset_req <= 1'b1;
    repeat (5) @(posedge pclk);
    reset_req <= 1'b0;
    wait_for(0, 600);
    wait_for(2, 1500);
    chk("st_status", 2'b00, self_test_status);
    chk("flushes", 3, flush_cnt);
    apb(0, `CRB_OFF_STATUS, 32'h31a4, 0);
    apb(0, `CRB_OFF_CTRL, 32'h103, 0);
    wait_for(4, 200);
    wait_for(3, 200);
    t0 = cyc;
    wait_for(4, 200);
    wait_for(3, 200);
    chk("rom_period", `CRB_ROM_PERIOD, cyc - t0);
    wait_for(5, 26000);
    chk("fill_index", 0, icache_fill_index);
    @(posedge pclk);
    // The board model flips its data bit once per ROM clock.
    chk("fill_bits", `CRB_FILL_BITS, shift_cnt);
    chk("fill_ones", `CRB_FILL_BITS / 2, ones_cnt);
    power_on <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("pulldown", 1, pin_pulldown_en);
    chk("core_rst", 0, core_reset_n);
    chk("rom_oe_n", 1, rom_oe_n);
    chk("rom_clk", 0, rom_clk);
    end_of_test();
  end
endmodule
